/* File: rtl/rsu_controller.sv */
// Purpose: Remote image update controller with watchdog and serial access.
// Assumes: Fabric pins and the user shift clock are asynchronous to pclk.
// Notes: The user shift clock is oversampled; keep it well below pclk/4.
//
// Contract
// - After reset the factory image at page zero loads, control word cleared.
// - Any page address value is accepted as an application start address.
// - Watchdog expiry records its cause and reloads the factory image.
// - Watchdog stays disabled whenever the factory image is loaded.
// - Each trigger writes its own cause into the status register.
// - Configuration errors load the factory image without user action.
// - A successful application load enters user mode.
// - A fabric shift register samples update, status, control and writes update.
// - Control holds page address, watchdog settings and image-type flag.
// - Capture in an application image copies control into the shift chain.
// - Only a fabric or software reconfiguration request copies the update word into control.
// - Update word changes only in factory image, via an update operation.
// - Capture in factory image copies the update word into the shift chain.
// - Status rewritten each reconfiguration and captured into the chain.
// - Watchdog counts on the 10 MHz time base; control and status update on pclk.
// - Shift and update registers advance on the user shift clock.
// - Control layout: flag bit 0, page, enable bit 25, 12 timer bits.
// - Flag high makes update read-only; flag low disables the watchdog.
// - Status is five cause bits in documented order, cleared at reset.
`timescale 1ns/1ps
module rsu_controller import rsu_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fabric serial access port.
	input wire logic upgrade_user_clock,
	input wire logic upgrade_serial_in,
	input wire logic upgrade_shift_not_load,
	input wire logic upgrade_capture_not_update,
	output logic upgrade_serial_out,
	// Fabric reconfiguration and watchdog controls.
	input wire logic fabric_reconfig_request_n,
	input wire logic watchdog_restart_n,
	// Configuration pins and loader feedback.
	input wire logic config_error_line_n,
	input wire logic ext_reconfig_n,
	input wire logic crc_error,
	input wire logic image_loaded,
	// Loader commands and state.
	output logic reconfig_start,
	output logic [23:0] image_page_address,
	output logic user_mode
);

	// ********************************************************************
	// Input synchronisation and edge detection
	// ********************************************************************
	// Active-low lines rest high and all others low, so reset makes no edge.
	localparam logic [PIN_W-1:0] PIN_IDLE = 10'h0f0;
	logic [PIN_W-1:0] pins_s;
	logic [PIN_W-1:0] pins_prev_reg;
	logic s_uclk, s_sin, s_shift, s_capt, s_freq_n, s_wdrst_n;
	logic s_err_n, s_ext_n, s_crc, s_loaded;
	logic uclk_rise, freq_fall, err_fall, ext_fall, crc_rise, loaded_rise;

	rsu_sync #(
		.WIDTH(PIN_W),
		.RESET_VAL(PIN_IDLE)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d_in({image_loaded, crc_error, ext_reconfig_n,
			config_error_line_n, watchdog_restart_n,
			fabric_reconfig_request_n, upgrade_capture_not_update,
			upgrade_shift_not_load, upgrade_serial_in,
			upgrade_user_clock}),
		.q_out(pins_s)
	);

	assign {s_loaded, s_crc, s_ext_n, s_err_n, s_wdrst_n, s_freq_n,
		s_capt, s_shift, s_sin, s_uclk} = pins_s;

	// Previous synchronised levels, for edge detection only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_prev_reg <= PIN_IDLE;
		end else begin
			pins_prev_reg <= pins_s;
		end
	end

	// Edges are taken after both synchroniser stages.
	assign uclk_rise = s_uclk & ~pins_prev_reg[0];
	assign freq_fall = ~s_freq_n & pins_prev_reg[4];
	assign err_fall = ~s_err_n & pins_prev_reg[6];
	assign ext_fall = ~s_ext_n & pins_prev_reg[7];
	assign crc_rise = s_crc & ~pins_prev_reg[8];
	assign loaded_rise = s_loaded & ~pins_prev_reg[9];

	// ********************************************************************
	// Slow time base
	// ********************************************************************
	logic [OSC_DIV_W-1:0] div_reg, div_next;
	logic osc_tick;

	// A one-cycle enable stands in for the slow oscillator clock.
	always_comb begin
		osc_tick = (div_reg == OSC_DIV_LAST);
		div_next = osc_tick ? '0 : div_reg + 5'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// ********************************************************************
	// Reconfiguration state, control, status and watchdog
	// ********************************************************************
	rsu_state_t state_reg, state_next;
	rsu_ctrl_t ctrl_reg, ctrl_next;
	rsu_ctrl_t update_reg;
	rsu_status_t status_reg, status_next, cause;
	logic [WD_CNT_W-1:0] wd_cnt_reg, wd_cnt_next, wd_limit;
	logic boot_reg, boot_next;
	logic start_reg, start_next;
	logic user_reg, user_next;
	logic sw_reconfig;
	logic wd_run, wd_expire, core_req, trigger;

	// Trigger priority: pin reset, error line, CRC, watchdog, fabric.
	// A fabric request in a loading image is ignored, as there is no
	// user logic yet to have issued it meaningfully.
	always_comb begin
		wd_limit = {ctrl_reg.watchdog_timeout_field,
			{WD_LOW_ZEROS{1'b0}}};
		wd_run = (state_reg == RSU_ST_USER) &&
			ctrl_reg.application_image_flag &&
			ctrl_reg.watchdog_enable_bit;
		wd_expire = wd_run && (wd_cnt_reg >= wd_limit);
		core_req = (freq_fall || sw_reconfig) &&
			(state_reg == RSU_ST_USER);
		cause = STATUS_RESET;
		trigger = 1'b1;
		if (ext_fall) begin
			cause.ext_reconfig = 1'b1;
		end else if (err_fall) begin
			cause.config_error = 1'b1;
		end else if (crc_rise && state_reg == RSU_ST_LOAD) begin
			cause.crc_error = 1'b1;
		end else if (wd_expire) begin
			cause.watchdog = 1'b1;
		end else if (core_req) begin
			cause.fabric_reconfig = 1'b1;
		end else begin
			trigger = 1'b0;
		end
	end

	// Next state of the image loader and its registers.
	always_comb begin
		state_next = state_reg;
		ctrl_next = ctrl_reg;
		status_next = status_reg;
		boot_next = 1'b0;
		start_next = 1'b0;
		if (boot_reg) begin
			// First cycle after reset: load page zero.
			start_next = 1'b1;
			state_next = RSU_ST_LOAD;
		end else if (trigger) begin
			status_next = cause;
			if (cause.fabric_reconfig) begin
				ctrl_next = update_reg;
			end else begin
				ctrl_next = CTRL_RESET;
			end
			start_next = 1'b1;
			state_next = RSU_ST_LOAD;
		end else if (state_reg == RSU_ST_LOAD && loaded_rise) begin
			state_next = RSU_ST_USER;
		end
		user_next = (state_next == RSU_ST_USER);
	end

	// The count restarts on fabric request and whenever it may not run.
	always_comb begin
		if (!wd_run || !s_wdrst_n || trigger) begin
			wd_cnt_next = '0;
		end else if (osc_tick) begin
			wd_cnt_next = wd_cnt_reg + 29'(1);
		end else begin
			wd_cnt_next = wd_cnt_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= RSU_ST_LOAD;
			ctrl_reg <= CTRL_RESET;
			status_reg <= STATUS_RESET;
			wd_cnt_reg <= '0;
			boot_reg <= 1'b1;
			start_reg <= 1'b0;
			user_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			wd_cnt_reg <= wd_cnt_next;
			boot_reg <= boot_next;
			start_reg <= start_next;
			user_reg <= user_next;
		end
	end

	assign reconfig_start = start_reg;
	assign image_page_address = ctrl_reg.image_page_address;
	assign user_mode = user_reg;

	// ********************************************************************
	// Serial shift and update registers
	// ********************************************************************
	logic [SHIFT_W-1:0] shift_reg, shift_next;
	rsu_ctrl_t update_next;

	// All actions happen on a rising edge of the user shift clock.
	always_comb begin
		shift_next = shift_reg;
		update_next = update_reg;
		if (uclk_rise) begin
			if (s_shift) begin
				shift_next = {s_sin, shift_reg[SHIFT_W-1:1]};
			end else if (s_capt) begin
				if (ctrl_reg.application_image_flag) begin
					shift_next = {ctrl_reg, status_reg};
				end else begin
					shift_next = {update_reg, status_reg};
				end
			end else if (!ctrl_reg.application_image_flag) begin
				update_next = shift_reg[SHIFT_W-1:STAT_W];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= '0;
			update_reg <= CTRL_RESET;
		end else begin
			shift_reg <= shift_next;
			update_reg <= update_next;
		end
	end

	assign upgrade_serial_out = shift_reg[0];

	// ********************************************************************
	// APB register access
	// ********************************************************************
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic setup, access;

	// Read data is chosen in the setup cycle so that it leaves a flop.
	always_comb begin
		setup = psel && !penable;
		access = psel && penable && pready_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		pready_next = setup;
		sw_reconfig = access && pwrite && (paddr == ADDR_COMMAND) &&
			pwdata[CMD_RECONFIG_BIT];
		if (setup) begin
			prdata_next = 32'h0000_0000;
			if (paddr == ADDR_CTRL_LO) begin
				prdata_next = ctrl_reg[31:0];
			end else if (paddr == ADDR_CTRL_HI) begin
				prdata_next = {26'h000_0000, ctrl_reg[CTRL_W-1:32]};
			end else if (paddr == ADDR_STATUS) begin
				prdata_next[STAT_W-1:0] = status_reg;
				prdata_next[STAT_USER_BIT] = user_reg;
			end else if (paddr == ADDR_UPD_LO) begin
				prdata_next = update_reg[31:0];
			end else if (paddr == ADDR_UPD_HI) begin
				prdata_next = {26'h000_0000, update_reg[CTRL_W-1:32]};
			end else if (paddr == ADDR_WD_COUNT) begin
				prdata_next = {3'h0, wd_cnt_reg};
			end else if (paddr != ADDR_COMMAND) begin
				pslverr_next = 1'b1;
			end
		end else if (psel && penable && !pready_reg) begin
			pslverr_next = pslverr_reg;
		end
		if (setup && pwrite) begin
			// Only the command register accepts writes.
			pslverr_next = (paddr != ADDR_COMMAND);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

endmodule : rsu_controller

/* File: inc/rsu_pkg.sv */
// Purpose: Shared constants and types for the remote image update block.
// Assumes: pclk at 200 MHz; all fabric and pin inputs are asynchronous.
// Notes: The control word layout doubles as the update word layout.
package rsu_pkg;

	// ********************************************************************
	// Clocking and watchdog timing
	// ********************************************************************
	localparam int PCLK_HZ = 200_000_000;
	localparam int OSC_HZ = 10_000_000;
	// Cycles of pclk for one tick of the slow watchdog time base.
	localparam int OSC_DIV = PCLK_HZ / OSC_HZ;
	localparam int OSC_DIV_W = 5;
	localparam logic [OSC_DIV_W-1:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);
	localparam int WD_CNT_W = 29;
	localparam int WD_LOW_ZEROS = 17;

	// ********************************************************************
	// Word layouts, positions and reset values
	// ********************************************************************
	localparam int ANF_BIT = 0;
	localparam int PAGE_LSB = 1;
	localparam int WATCHDOG_ENABLE_BIT_BIT = 25;
	localparam int WATCHDOG_TIMEOUT_FIELD_LSB = 26;
	localparam int CTRL_W = 38;
	localparam int STAT_W = 5;
	localparam int SHIFT_W = CTRL_W + STAT_W;
	localparam int PIN_W = 10;

	// Control and update word, most significant field first.
	typedef struct packed {
		logic [11:0] watchdog_timeout_field;
		logic watchdog_enable_bit;
		logic [23:0] image_page_address;
		logic application_image_flag;
	} rsu_ctrl_t;

	// Cause of the most recent reconfiguration, one bit per trigger.
	typedef struct packed {
		logic watchdog;
		logic ext_reconfig;
		logic fabric_reconfig;
		logic config_error;
		logic crc_error;
	} rsu_status_t;

	localparam rsu_ctrl_t CTRL_RESET = 38'h00_0000_0000;
	localparam rsu_status_t STATUS_RESET = 5'h00;

	// ********************************************************************
	// APB register offsets (byte addresses)
	// ********************************************************************
	localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
	localparam logic [7:0] ADDR_CTRL_HI = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_UPD_LO = 8'h0c;
	localparam logic [7:0] ADDR_UPD_HI = 8'h10;
	localparam logic [7:0] ADDR_COMMAND = 8'h14;
	localparam logic [7:0] ADDR_WD_COUNT = 8'h18;
	localparam int CMD_RECONFIG_BIT = 0;
	localparam int STAT_USER_BIT = 8;

	// Image load states.
	typedef enum logic [0:0] {
		RSU_ST_LOAD,
		RSU_ST_USER
	} rsu_state_t;

endpackage : rsu_pkg

/* File: rtl/rsu_sync.sv */
// Purpose: Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes: Bits are independent levels; no bus coherence is implied.
// Notes: The reset value lets active-low lines rest at their idle level.
`timescale 1ns/1ps
module rsu_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous inputs and their synchronised copies.
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;

endmodule : rsu_sync

/* File: verification/rsu_controller_properties.sv */
// Purpose: Port-level checker for the update controller.
// Assumes: Sees only the controller's own ports.
// Notes: Bound to every controller instance.
`timescale 1ns/1ps
module rsu_controller_properties (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Fabric port and loader.
	input wire logic upgrade_user_clock,
	input wire logic upgrade_serial_out,
	input wire logic image_loaded,
	input wire logic reconfig_start,
	input wire logic [23:0] image_page_address,
	input wire logic user_mode
);
	// ****
	// Properties
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus timing; the master relies on a one-cycle answer.
	a_setup_answer: assert property (
		psel && !penable |=> pready) else $error("no answer");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready too long");
	a_read_holds: assert property (
		!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	// Loader pulses and the page they start from.
	a_start_single: assert property (
		reconfig_start |=> !reconfig_start) else $error("long start");
	a_start_ends_user: assert property (
		reconfig_start |-> !user_mode) else $error("user during start");
	a_factory_page: assert property (
		reconfig_start && !$past(user_mode) |-> image_page_address == 24'h0)
		else $error("factory start not page zero");
	a_page_with_start: assert property (
		$changed(image_page_address) |-> ##[0:2] reconfig_start)
		else $error("page moved without start");
	a_user_after_load: assert property (
		$rose(user_mode) |-> $past(image_loaded)) else $error("early user");
	// The chain only moves on a user clock rise.
	a_serial_quiet: assert property (
		!upgrade_user_clock [*8] |=> $stable(upgrade_serial_out))
		else $error("serial out moved");
endmodule : rsu_controller_properties

bind rsu_controller rsu_controller_properties i_props (.pclk, .presetn,
	.psel, .penable, .prdata, .pready, .pslverr, .upgrade_user_clock,
	.upgrade_serial_out, .image_loaded, .reconfig_start,
	.image_page_address, .user_mode);

/* File: verification/rsu_fabric_model.sv */
// Purpose: Fabric user logic facing the serial update port.
// Assumes: pclk paces the link clock, 32 pclk per period.
// Notes: The link clock stands low between frames.
`timescale 1ns/1ps
module rsu_fabric_model (
	// Clock.
	input wire logic pclk,
	// Serial port.
	output logic upgrade_user_clock,
	output logic upgrade_serial_in,
	output logic upgrade_shift_not_load,
	output logic upgrade_capture_not_update,
	input wire logic upgrade_serial_out,
	// Reconfiguration and watchdog.
	output logic fabric_reconfig_request_n,
	output logic watchdog_restart_n
);
	// Idle levels at time zero.
	initial begin
		upgrade_user_clock = 1'h0;
		upgrade_serial_in = 1'h0;
		upgrade_shift_not_load = 1'h0;
		upgrade_capture_not_update = 1'h0;
		fabric_reconfig_request_n = 1'h1;
		watchdog_restart_n = 1'h1;
	end
	// One link clock period; controls settle long before the rise.
	task automatic tick(input logic sh, input logic cp, input logic d,
		output logic q);
		@(posedge pclk);
		upgrade_shift_not_load <= sh;
		upgrade_capture_not_update <= cp;
		upgrade_serial_in <= d;
		// The entry edge plus 15 more keeps the low phase at 16 pclk.
		repeat (15) @(posedge pclk);
		q = upgrade_serial_out;
		upgrade_user_clock <= 1'h1;
		repeat (16) @(posedge pclk);
		upgrade_user_clock <= 1'h0;
	endtask : tick
	// Full 43-bit frame, first bit in ends at bit 0.
	task automatic xfer(input logic [42:0] din, output logic [42:0] dout);
		for (int i = 0; i < 43; i++) begin
			tick(1'h1, 1'h0, din[i], dout[i]);
		end
		upgrade_serial_in <= ~din[42]; // A released line shows no stale bit.
	endtask : xfer
	// Request held for the full minimum low time.
	task automatic request();
		fabric_reconfig_request_n <= 1'h0;
		repeat (50) @(posedge pclk);
		fabric_reconfig_request_n <= 1'h1;
	endtask : request
	// Health pulse of a working application.
	task automatic restart();
		watchdog_restart_n <= 1'h0;
		repeat (4) @(posedge pclk);
		watchdog_restart_n <= 1'h1;
	endtask : restart
endmodule : rsu_fabric_model

/* File: verification/rsu_controller_bench.sv */
// Purpose: Self-checking bench for the update controller.
// Assumes: Bench drives APB and pins; the model drives the fabric port.
// Notes: A zero time-out makes the watchdog expire at once.
`timescale 1ns/1ps
module rsu_controller_bench import rsu_pkg::*;;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} rsu_row_t;
	// Reset values, then refused accesses, then proof of no effect.
	localparam rsu_row_t ROWS [9] = '{
		{1'h0, 8'h08, 32'h0, 32'h0, 1'h0}, {1'h0, 8'h00, 32'h0, 32'h0, 1'h0},
		{1'h0, 8'h04, 32'h0, 32'h0, 1'h0}, {1'h0, 8'h0c, 32'h0, 32'h0, 1'h0},
		{1'h0, 8'h18, 32'h0, 32'h0, 1'h0}, {1'h0, 8'h1c, 32'h0, 32'h0, 1'h1},
		{1'h1, 8'h00, 32'hffff_ffff, 32'h0, 1'h1},
		{1'h1, 8'h08, 32'hffff_ffff, 32'h0, 1'h1},
		{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}};
	localparam logic [4:0] CAUSE [3] = '{5'h02, 5'h01, 5'h08};
	localparam rsu_ctrl_t W1 = '{12'h001, 1'h0, 24'h000123, 1'h1};
	localparam rsu_ctrl_t W2 = '{12'h000, 1'h1, 24'h000456, 1'h1};
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, upgrade_serial_out, reconfig_start, user_mode;
	logic upgrade_user_clock, upgrade_serial_in, upgrade_shift_not_load;
	logic upgrade_capture_not_update, fabric_reconfig_request_n;
	logic watchdog_restart_n, crc_error = 1'h0, image_loaded = 1'h0;
	logic config_error_line_n = 1'h1, ext_reconfig_n = 1'h1;
	logic [23:0] image_page_address;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	rsu_controller i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .upgrade_user_clock,
		.upgrade_serial_in, .upgrade_shift_not_load,
		.upgrade_capture_not_update, .upgrade_serial_out,
		.fabric_reconfig_request_n, .watchdog_restart_n, .config_error_line_n,
		.ext_reconfig_n, .crc_error, .image_loaded, .reconfig_start,
		.image_page_address, .user_mode);
	rsu_fabric_model i_fab (.pclk, .upgrade_user_clock, .upgrade_serial_in,
		.upgrade_shift_not_load, .upgrade_capture_not_update,
		.upgrade_serial_out, .fabric_reconfig_request_n, .watchdog_restart_n);
	// 200 MHz clock and a cycle ceiling that cuts a hang short.
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string n, input logic [42:0] s, x);
		samples_checked++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : check
	// One APB transfer, held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Sample at the rising edge, where the slave sees its own answer.
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// One idle edge, so a following call never re-raises psel at once.
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		check("prdata", 43'(q), 43'(x));
	endtask : rd
	// Waits for a loader start, bounded, and checks its page.
	task automatic wait_start(input logic [23:0] pg);
		int n;
		n = 0;
		while (reconfig_start !== 1'h1 && n < 400) begin
			@(negedge pclk);
			n++;
		end
		check("start", 43'(reconfig_start), 43'h1);
		check("page", 43'(image_page_address), 43'(pg));
		@(posedge pclk);
	endtask : wait_start
	task automatic load();
		image_loaded <= 1'h0;
		repeat (8) @(posedge pclk);
		image_loaded <= 1'h1;
		repeat (20) @(posedge pclk);
		check("user", 43'(user_mode), 43'h1);
	endtask : load
	task automatic upd(input rsu_ctrl_t w);
		logic [42:0] c;
		logic b;
		i_fab.xfer({w, 5'h00}, c);
		i_fab.tick(1'h0, 1'h0, 1'h0, b);
	endtask : upd
	task automatic cap(input logic [42:0] x);
		logic [42:0] c;
		logic b;
		i_fab.tick(1'h0, 1'h1, 1'h0, b);
		i_fab.xfer(43'h0, c);
		check("chain", c, x);
	endtask : cap
	task automatic trig(input int i);
		case (i)
			0: config_error_line_n <= 1'h0;
			1: crc_error <= 1'h1;
			default: ext_reconfig_n <= 1'h0;
		endcase
		repeat (10) @(posedge pclk);
		config_error_line_n <= 1'h1;
		crc_error <= 1'h0;
		ext_reconfig_n <= 1'h1;
	endtask : trig
	// Main sequence: table first, then hand-written cases.
	initial begin
		logic [31:0] q;
		logic e;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		check("page", 43'(image_page_address), 43'h0);
		@(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, q, e);
			check("slverr", 43'(e), 43'(ROWS[i].e));
			if (!ROWS[i].e) check("rdata", 43'(q), 43'(ROWS[i].x));
		end
		load();
		rd(8'h08, 32'h100);
		upd(W1);
		cap({W1, 5'h00});
		rd(8'h0c, W1[31:0]);
		rd(8'h10, 32'(W1[37:32]));
		fork
			i_fab.request();
			wait_start(W1.image_page_address);
		join
		rd(8'h08, 32'h4);
		load();
		i_fab.restart();
		rd(8'h00, W1[31:0]);
		rd(8'h04, 32'(W1[37:32]));
		cap({W1, 5'h04});
		upd(38'h15_5555_5555);
		fork
			trig(0);
			wait_start(24'h0);
		join
		load();
		cap({W1, 5'h02});
		upd(W2);
		fork
			i_fab.request();
			wait_start(W2.image_page_address);
		join
		image_loaded <= 1'h0;
		repeat (8) @(posedge pclk);
		image_loaded <= 1'h1;
		wait_start(24'h0);
		rd(8'h08, 32'h10);
		load();
		repeat (300) @(posedge pclk);
		check("user", 43'(user_mode), 43'h1);
		// Software request through the command word loads the update word.
		fork
			apb(1'h1, 8'h14, 32'h1, q, e);
			wait_start(W2.image_page_address);
		join
		check("slverr", 43'(e), 43'h0);
		rd(8'h08, 32'h4);
		for (int i = 0; i < 3; i++) begin
			fork
				trig(i);
				wait_start(24'h0);
			join
			rd(8'h08, 32'(CAUSE[i]));
		end
		// A second reset in mid-run must clear status and reload page zero.
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		wait_start(24'h0);
		rd(8'h08, 32'h0);
		finish_test();
	end
endmodule : rsu_controller_bench
